// *** include/dual_host_pkg.sv ***
// Shared constants and types of the dual host access port
package dual_host_pkg;

    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 4;

    // Serial roles of the low multiplexed lines
    localparam int SER_IN_BIT  = 0;
    localparam int SER_OUT_BIT = 1;
    localparam int SER_CLK_BIT = 2;
    localparam int SER_DIR_BIT = 3;

    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] BUS_RESET  = 8'h00;
    localparam logic [7:0] OE_ALL_OFF = 8'hFF;
    localparam logic [7:0] OE_ALL_ON  = 8'h00;
    localparam logic [7:0] ADDR_STEP  = 8'h01;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [2:0] BIT_FIRST  = 3'h0;

    // Direction line level that asks for a read
    localparam logic DIR_READ = 1'b1;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       ale;
        logic       mode_sel;
        logic       edge_sel;
        logic [7:0] ad;
    } pins_t;

    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
                                    mode_sel: 1'b0, edge_sel: 1'b0, ad: 8'h00};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } reg_write_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_ADDR = 2'b01,
        SER_DATA = 2'b10
    } ser_phase_t;

endpackage

// *** verification/dual_host_interface_tb.sv ***
// Self-checking bench of the dual host access port
`timescale 1ns/1ps
module dual_host_interface_tb;
    logic        clock, nrst, mode_sel, edge_sel, step_en, wr_ready, lost_clear, flt;
    logic        cs_n, rd_n, wr_n, ale, wr_valid, lost;
    logic [7:0]  host_ad, host_oe_n, bus_in, dev_out, dev_oe_n, rd_addr, rdata, d, on, off;
    logic [15:0] got[$];
    int          fail_count, total_checks, cycles;
    dual_host_pkg::reg_write_t wr_word;

    // Core register stand-in: read data is a fixed mix of the address
    assign rdata = rd_addr ^ 8'hC3;
    // Lines nobody drives toggle, so a stale value never passes for data
    assign bus_in = (~dev_oe_n & dev_out) | (dev_oe_n & ~host_oe_n & host_ad)
                  | (dev_oe_n & host_oe_n & {8{flt}});

    dual_host_interface #(.DEPTH(dual_host_pkg::FIFO_DEPTH)) u_dut (
        .clock(clock), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
        .interface_select_pin(mode_sel), .output_edge_select(edge_sel),
        .muxed_bus_lines_in(bus_in), .muxed_bus_lines_out(dev_out),
        .muxed_bus_lines_oe_n(dev_oe_n), .address_auto_step_enable(step_en),
        .reg_rd_addr(rd_addr), .reg_rdata(rdata), .reg_wr_valid(wr_valid),
        .reg_wr_word(wr_word), .reg_wr_ready(wr_ready), .write_lost(lost),
        .write_lost_clear(lost_clear));

    host_model u_host (
        .clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ad(host_ad),
        .ad_oe_n(host_oe_n), .bus(bus_in), .dev_oe_n(dev_oe_n));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        flt <= ~flt;
        if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_word);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic do_reset(input logic m);
        @(negedge clock);
        nrst = 1'b0;
        mode_sel = m;
        repeat (2) @(negedge clock);
        check({dev_oe_n, rd_addr}, 16'hFF00);
        check({wr_valid, lost}, 2'b00);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
    endtask

    // Fill the write buffer past full, then drain it
    task automatic t_par_write();
        got.delete();
        for (int i = 0; i < 4; i++) u_host.par_write(8'(8'h10 + i), 8'(8'hA0 + i), 1'b0);
        u_host.par_write(8'h20, 8'h55, 1'b1);
        check(lost, 1'b0);
        check({wr_valid, wr_word}, 17'h1_10A0);
        u_host.par_write(8'h21, 8'h66, 1'b0);
        check(lost, 1'b1);
        lost_clear = 1'b1;
        @(negedge clock);
        lost_clear = 1'b0;
        check(lost, 1'b0);
        wr_ready = 1'b1;
        repeat (8) @(negedge clock);
        check(16'(got.size()), 16'h0004);
        for (int i = 0; i < 4; i++) check(got[i], {8'(8'h10 + i), 8'(8'hA0 + i)});
    endtask

    task automatic t_par_read();
        u_host.par_read(8'h5A, 1'b0, d, on, off);
        check(d, 8'h5A ^ 8'hC3);
        check({on, off}, 16'h00FF);
        u_host.par_read(8'h33, 1'b1, d, on, off);
        check({on, rd_addr}, 16'hFF33);
    endtask

    task automatic t_ser_write();
        got.delete();
        step_en = 1'b1;
        u_host.ser_begin(1'b0);
        u_host.ser_byte(8'h3C, 8, 1'b0, d);
        check(rd_addr, 8'h3C);
        u_host.ser_byte(8'h81, 8, 1'b0, d);
        u_host.ser_byte(8'h7E, 8, 1'b0, d);
        u_host.ser_end();
        check(got[0], 16'h3C81);
        check(got[1], 16'h3D7E);
        check(rd_addr, 8'h3E);
        // Aborted partial byte must leave nothing behind
        u_host.ser_begin(1'b0);
        u_host.ser_byte(8'hFF, 5, 1'b0, d);
        u_host.ser_end();
        step_en = 1'b0;
        u_host.ser_begin(1'b0);
        u_host.ser_byte(8'h22, 8, 1'b0, d);
        u_host.ser_byte(8'h11, 8, 1'b0, d);
        u_host.ser_byte(8'h44, 8, 1'b0, d);
        u_host.ser_end();
        check(16'(got.size()), 16'h0004);
        check(got[2], 16'h2211);
        check(got[3], 16'h2244);
        u_host.par_addr(8'h99);
        check({dev_oe_n, rd_addr}, 16'hFF22);
    endtask

    task automatic t_ser_read(input logic e);
        edge_sel = e;
        step_en = 1'b1;
        u_host.ser_begin(1'b1);
        u_host.ser_byte(8'h40, 8, e, d);
        u_host.ser_byte(8'h00, 8, e, d);
        check(d, 8'h40 ^ 8'hC3);
        u_host.ser_byte(8'h00, 8, e, d);
        check(d, 8'h41 ^ 8'hC3);
        check(dev_oe_n, 8'hFD);
        u_host.ser_end();
        check(dev_oe_n, 8'hFF);
    endtask

    initial begin
        {nrst, mode_sel, edge_sel, step_en, wr_ready, lost_clear, flt} = 7'h00;
        cycles = 0;
        fail_count = 0;
        total_checks = 0;
        do_reset(1'b0);
        t_par_write();
        t_par_read();
        do_reset(1'b1);
        t_ser_write();
        t_ser_read(1'b0);
        t_ser_read(1'b1);
        report_and_stop();
    end
endmodule

// *** verification/host_model.sv ***
// Host side model driving the parallel and serial pins of the access port
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic       clock,
    // Pins toward the device
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            ale,
    output logic [7:0]      ad,
    output logic [7:0]      ad_oe_n,
    // Resolved bus and device enables
    input  wire logic [7:0] bus,
    input  wire logic [7:0] dev_oe_n
);
    initial begin
        {cs_n, rd_n, wr_n, ale} = 4'b1110;
        ad = 8'h00;
        ad_oe_n = 8'h00;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Address is held well past the falling latch strobe
    task automatic par_addr(input logic [7:0] a);
        ad = a;
        ale = 1'b1;
        wait_n(4);
        ale = 1'b0;
        wait_n(4);
    endtask

    task automatic par_write(input logic [7:0] a, input logic [7:0] dt, input logic sel_n);
        par_addr(a);
        ad = dt;
        cs_n = sel_n;
        wr_n = 1'b0;
        wait_n(4);
        wr_n = 1'b1;
        wait_n(4);
        cs_n = 1'b1;
        wait_n(4);
    endtask

    // Host lets go of the bus for the whole read strobe
    task automatic par_read(input logic [7:0] a, input logic sel_n, output logic [7:0] dt,
                            output logic [7:0] oe_on, output logic [7:0] oe_off);
        par_addr(a);
        ad_oe_n = 8'hFF;
        cs_n = sel_n;
        rd_n = 1'b0;
        wait_n(5);
        dt = bus;
        oe_on = dev_oe_n;
        rd_n = 1'b1;
        wait_n(5);
        oe_off = dev_oe_n;
        cs_n = 1'b1;
        ad_oe_n = 8'h00;
        wait_n(2);
    endtask

    // Unused parallel pins parked low; serial out left to the device
    task automatic ser_begin(input logic rd_dir);
        ad = {4'h0, rd_dir, 3'b000};
        ad_oe_n = 8'h02;
        cs_n = 1'b0;
        wait_n(4);
    endtask

    // Link clock idles low between frames; n bits go out MSB first
    task automatic ser_byte(input logic [7:0] tx, input int n, input logic fall,
                            output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            ad[0] = tx[i];
            ad[2] = 1'b0;
            wait_n(10);
            if (fall) rx[i] = bus[1];
            ad[2] = 1'b1;
            wait_n(10);
            if (!fall) rx[i] = bus[1];
        end
    endtask

    task automatic ser_end();
        ad[2] = 1'b0;
        wait_n(10);
        cs_n = 1'b1;
        wait_n(4);
        ad_oe_n = 8'h00;
        wait_n(2);
    endtask
endmodule

// *** verilog/dual_host_interface.sv ***
// Parallel and serial host access port of the message-bus controller
//
// What this block does, and what it expects of the board and host
// R01 - Select pin high: serial lines active, upper lines and parallel strobes ignored.
// R02 - Select pin low: parallel port with all eight lines and strobes active.
// R03 - Board holds the select pin steady while operating.
// R04 - Parallel address captured from the bus on the latch strobe falling edge.
// R05 - Low write strobe writes bus data; low read strobe drives register data out.
// R06 - Parallel accesses count only while chip select is low.
// R07 - In serial mode host ties unused parallel pins inactive.
// R08 - Serial access starts with chip select low; first byte is the address.
// R09 - Direction line high reads data bytes, low writes them.
// R10 - With auto-step enabled the address steps after every data byte.
// R11 - Host ends each serial access by raising chip select.
// R12 - Serial bytes travel most significant bit first both ways.
// R13 - Serial input is sampled on each rising serial clock edge.
// R14 - Edge select low: serial output changes on rising clock edges.
// R15 - Edge select high: serial output changes on falling clock edges.
// R16 - Eight edges make a byte; deselect clears bit count and phase.
// R17 - Serial write stores before stepping; read loads before first output edge.
`timescale 1ns/1ps
module dual_host_interface #(
    parameter int DEPTH = dual_host_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       nrst,
    // Host pins
    input  wire logic                       cs_n,
    input  wire logic                       rd_n,
    input  wire logic                       wr_n,
    input  wire logic                       ale,
    input  wire logic                       interface_select_pin,
    input  wire logic                       output_edge_select,
    input  wire logic [7:0]                 muxed_bus_lines_in,
    output logic      [7:0]                 muxed_bus_lines_out,
    output logic      [7:0]                 muxed_bus_lines_oe_n,
    // Core register side
    input  wire logic                       address_auto_step_enable,
    output logic      [7:0]                 reg_rd_addr,
    input  wire logic [7:0]                 reg_rdata,
    output logic                            reg_wr_valid,
    output dual_host_pkg::reg_write_t       reg_wr_word,
    input  wire logic                       reg_wr_ready,
    // Status
    output logic                            write_lost,
    input  wire logic                       write_lost_clear
);
    typedef struct packed {
        dual_host_pkg::pins_t       s1;
        dual_host_pkg::pins_t       s2;
        dual_host_pkg::pins_t       prev;
        logic [7:0]                 addr;
        dual_host_pkg::ser_phase_t  phase;
        logic [2:0]                 bits;
        logic [7:0]                 rx;
        logic [7:0]                 tx;
        logic                       load_pend;
        logic                       so;
        logic [7:0]                 bus_out;
        logic [7:0]                 bus_oe_n;
        logic                       lost;
        logic                       push;
        dual_host_pkg::reg_write_t  push_word;
    } state_t;

    state_t                    st_reg;
    state_t                    st_next;
    dual_host_pkg::pins_t      pins;
    logic                      push_ready;
    logic                      ale_fall;
    logic                      wr_rise;
    logic                      sclk_rise;
    logic                      sclk_fall;
    logic                      out_edge;
    logic                      ser_active;
    logic                      byte_done;
    logic                      dir_read;
    logic [7:0]                rx_full;

    function automatic logic [7:0] step_addr(input logic [7:0] a, input logic en);
        step_addr = en ? a + dual_host_pkg::ADDR_STEP : a;
    endfunction

    assign pins = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, ale: ale,
                    mode_sel: interface_select_pin, edge_sel: output_edge_select,
                    ad: muxed_bus_lines_in};

    // Edges come from the second and third stages only
    assign ale_fall   = st_reg.prev.ale && !st_reg.s2.ale;
    assign wr_rise    = !st_reg.prev.wr_n && st_reg.s2.wr_n;
    assign sclk_rise  = !st_reg.prev.ad[dual_host_pkg::SER_CLK_BIT]
                        && st_reg.s2.ad[dual_host_pkg::SER_CLK_BIT];
    assign sclk_fall  = st_reg.prev.ad[dual_host_pkg::SER_CLK_BIT]
                        && !st_reg.s2.ad[dual_host_pkg::SER_CLK_BIT];
    assign out_edge   = st_reg.s2.edge_sel ? sclk_fall : sclk_rise;
    assign ser_active = st_reg.s2.mode_sel && !st_reg.s2.cs_n;
    assign byte_done  = ser_active && sclk_rise && (st_reg.bits == dual_host_pkg::BIT_LAST);
    assign dir_read   = (st_reg.s2.ad[dual_host_pkg::SER_DIR_BIT] == dual_host_pkg::DIR_READ);
    assign rx_full    = {st_reg.rx[6:0], st_reg.s2.ad[dual_host_pkg::SER_IN_BIT]};

    always_comb begin
        st_next          = st_reg;
        st_next.s1       = pins;
        st_next.s2       = st_reg.s1;
        st_next.prev     = st_reg.s2;
        st_next.push     = 1'b0;
        st_next.bus_oe_n = dual_host_pkg::OE_ALL_OFF;
        // A lost write in the clearing cycle stays flagged
        if (write_lost_clear) begin
            st_next.lost = 1'b0;
        end
        if (st_reg.push && !push_ready) begin
            st_next.lost = 1'b1;
        end
        if (!st_reg.s2.mode_sel) begin
            st_next.phase     = dual_host_pkg::SER_IDLE;   // [R02]
            st_next.bits      = dual_host_pkg::BIT_FIRST;
            st_next.load_pend = 1'b0;
            if (ale_fall) begin
                st_next.addr = st_reg.s2.ad;   // [R04]
            end
            // Data is taken as it stood just before the strobe rose
            if (wr_rise && !st_reg.prev.cs_n) begin
                st_next.push      = 1'b1;   // [R05] [R06]
                st_next.push_word = '{addr: st_reg.addr, data: st_reg.prev.ad};
            end
            if (!st_reg.s2.rd_n && !st_reg.s2.cs_n) begin
                st_next.bus_oe_n = dual_host_pkg::OE_ALL_ON;   // [R05] [R06]
                st_next.bus_out  = reg_rdata;
            end
        end else if (st_reg.s2.cs_n) begin
            st_next.phase     = dual_host_pkg::SER_IDLE;   // [R16]
            st_next.bits      = dual_host_pkg::BIT_FIRST;
            st_next.load_pend = 1'b0;
        end else begin
            // Only the output line is driven; strobes and upper lines are ignored
            st_next.bus_oe_n[dual_host_pkg::SER_OUT_BIT] = 1'b0;   // [R01]
            st_next.bus_out = dual_host_pkg::BUS_RESET;
            st_next.bus_out[dual_host_pkg::SER_OUT_BIT] = st_reg.so;
            if (st_reg.phase == dual_host_pkg::SER_IDLE) begin
                st_next.phase = dual_host_pkg::SER_ADDR;   // [R08]
            end
            if (sclk_rise) begin
                st_next.rx   = rx_full;   // [R13] [R12]
                st_next.bits = st_reg.bits + 1'b1;   // [R16]
            end
            // Read data reaches the shifter edges before its first output edge
            if (st_reg.load_pend) begin
                st_next.tx        = reg_rdata;   // [R17]
                st_next.load_pend = 1'b0;
            end else if (out_edge && st_reg.phase == dual_host_pkg::SER_DATA && dir_read) begin
                st_next.so = st_reg.tx[7];   // [R14] [R15] [R12]
                st_next.tx = {st_reg.tx[6:0], 1'b0};
            end
            if (byte_done) begin
                if (st_reg.phase != dual_host_pkg::SER_DATA) begin
                    st_next.addr      = rx_full;   // [R08]
                    st_next.phase     = dual_host_pkg::SER_DATA;
                    st_next.load_pend = dir_read;   // [R09]
                end else if (dir_read) begin
                    st_next.addr      = step_addr(st_reg.addr, address_auto_step_enable);
                    st_next.load_pend = 1'b1;   // [R10] [R17]
                end else begin
                    st_next.push      = 1'b1;   // [R09] [R17]
                    st_next.push_word = '{addr: st_reg.addr, data: rx_full};
                    st_next.addr      = step_addr(st_reg.addr, address_auto_step_enable);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg          <= '0;
            st_reg.s1       <= dual_host_pkg::PINS_IDLE;
            st_reg.s2       <= dual_host_pkg::PINS_IDLE;
            st_reg.prev     <= dual_host_pkg::PINS_IDLE;
            st_reg.addr     <= dual_host_pkg::ADDR_RESET;
            st_reg.phase    <= dual_host_pkg::SER_IDLE;
            st_reg.bus_out  <= dual_host_pkg::BUS_RESET;
            st_reg.bus_oe_n <= dual_host_pkg::OE_ALL_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    // Writes queue here so a slow core does not stall the host pins
    write_fifo #(
        .WIDTH ($bits(dual_host_pkg::reg_write_t)),
        .DEPTH (DEPTH)
    ) u_write_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (st_reg.push),
        .in_data   (st_reg.push_word),
        .in_ready  (push_ready),
        .out_valid (reg_wr_valid),
        .out_data  (reg_wr_word),
        .out_ready (reg_wr_ready)
    );

    assign muxed_bus_lines_out  = st_reg.bus_out;
    assign muxed_bus_lines_oe_n = st_reg.bus_oe_n;
    assign reg_rd_addr          = st_reg.addr;
    assign write_lost           = st_reg.lost;

    a_ale_capture: assert property (@(posedge clock) disable iff (!nrst) // [R04]
        (!st_reg.s2.mode_sel && ale_fall) |=> (st_reg.addr == $past(st_reg.s2.ad)))
        else $error("address not latched on strobe fall");

    a_par_write: assert property (@(posedge clock) disable iff (!nrst) // [R05]
        (!st_reg.s2.mode_sel && wr_rise && !st_reg.prev.cs_n)
        |=> (st_reg.push && st_reg.push_word.addr == $past(st_reg.addr)))
        else $error("parallel write not queued to latched address");

    a_cs_gates_write: assert property (@(posedge clock) disable iff (!nrst) // [R06]
        (!st_reg.s2.mode_sel && wr_rise && st_reg.prev.cs_n) |=> !st_reg.push)
        else $error("write taken without chip select");

    a_read_drive: assert property (@(posedge clock) disable iff (!nrst) // [R05]
        (!st_reg.s2.mode_sel && !st_reg.s2.rd_n && !st_reg.s2.cs_n)
        |=> (st_reg.bus_oe_n == dual_host_pkg::OE_ALL_ON && st_reg.bus_out == $past(reg_rdata)))
        else $error("read data not driven");

    a_serial_release: assert property (@(posedge clock) disable iff (!nrst) // [R01]
        st_reg.s2.mode_sel |=> ((st_reg.bus_oe_n | 8'h02) == dual_host_pkg::OE_ALL_OFF))
        else $error("serial mode drives a line other than the output");

    a_cs_restart: assert property (@(posedge clock) disable iff (!nrst) // [R16]
        (st_reg.s2.mode_sel && st_reg.s2.cs_n)
        |=> (st_reg.bits == dual_host_pkg::BIT_FIRST && st_reg.phase == dual_host_pkg::SER_IDLE))
        else $error("deselect did not clear serial state");

    a_addr_byte: assert property (@(posedge clock) disable iff (!nrst) // [R08]
        (byte_done && st_reg.phase != dual_host_pkg::SER_DATA)
        |=> (st_reg.addr == $past(rx_full) && st_reg.phase == dual_host_pkg::SER_DATA))
        else $error("first serial byte not taken as address");

    a_auto_step: assert property (@(posedge clock) disable iff (!nrst) // [R10]
        (byte_done && st_reg.phase == dual_host_pkg::SER_DATA && address_auto_step_enable)
        |=> (st_reg.addr == $past(st_reg.addr) + dual_host_pkg::ADDR_STEP))
        else $error("address did not step after data byte");

    a_ser_write: assert property (@(posedge clock) disable iff (!nrst) // [R17]
        (byte_done && st_reg.phase == dual_host_pkg::SER_DATA && !dir_read)
        |=> (st_reg.push && st_reg.push_word.addr == $past(st_reg.addr)))
        else $error("serial write not stored at current address");

    a_out_rise: assert property (@(posedge clock) disable iff (!nrst) // [R14]
        (ser_active && !st_reg.s2.edge_sel && sclk_rise && dir_read && !st_reg.load_pend
         && st_reg.phase == dual_host_pkg::SER_DATA) |=> (st_reg.so == $past(st_reg.tx[7])))
        else $error("output bit not shifted on rising edge");

    a_out_fall: assert property (@(posedge clock) disable iff (!nrst) // [R15]
        (ser_active && st_reg.s2.edge_sel && sclk_fall && dir_read && !st_reg.load_pend
         && st_reg.phase == dual_host_pkg::SER_DATA) |=> (st_reg.so == $past(st_reg.tx[7])))
        else $error("output bit not shifted on falling edge");

endmodule

// *** verilog/write_fifo.sv ***
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module write_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd;
        logic [PW-1:0]               wr;
        logic [CW-1:0]               count;
        logic                        valid;
        logic [WIDTH-1:0]            head;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        do_push;
    logic        do_pop;

    function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
        ptr_step = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (st_reg.count != CNT_FULL);
    assign out_valid = st_reg.valid;
    assign out_data  = st_reg.head;
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (do_push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr             = ptr_step(st_reg.wr);
        end
        if (do_pop) begin
            st_next.rd = ptr_step(st_reg.rd);
        end
        if (do_push && !do_pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (do_pop && !do_push) begin
            st_next.count = st_reg.count - 1'b1;
        end
        // Head word and valid are registered so the core sees flop outputs only
        st_next.valid = (st_next.count != '0);
        st_next.head  = st_next.mem[st_next.rd];
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule
